// ===== hw/mb_slave_pkg.sv
/*
 * Package for the serial slave port: timing figures, limits, function codes
 * and layout constants. Assumes a 100 MHz core clock.
 */
package mb_slave_pkg;
   // ==========================================================================
   // clock and time base
   localparam int          CLK_HZ        = 100_000_000;
   localparam int          MS_PER_S      = 1000;
   localparam int          CYC_PER_MS    = CLK_HZ / MS_PER_S;
   localparam logic [16:0] MS_CNT_MAX    = 17'(CYC_PER_MS - 1);
   // ==========================================================================
   // configuration limits
   localparam logic [7:0]  SLAVE_ID_MAX  = 8'hf7;    // 247
   localparam logic [11:0] BASE_MAX      = 12'hf9e;  // 3998
   localparam int          DB_AW         = 12;
   // ==========================================================================
   // function codes
   localparam logic [7:0]  FC_RD_COILS   = 8'h01;
   localparam logic [7:0]  FC_RD_INBITS  = 8'h02;
   localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
   localparam logic [7:0]  FC_RD_INREG   = 8'h04;
   localparam logic [7:0]  FC_WR_COIL    = 8'h05;
   localparam logic [7:0]  FC_WR_HOLD    = 8'h06;
   localparam logic [7:0]  FC_WR_COILS   = 8'h0f;
   localparam logic [7:0]  FC_WR_HOLDS   = 8'h10;
   // ==========================================================================
   // silence of 3.5 characters counted as 7 half-character ticks
   localparam logic [3:0]  SIL_HALF_CHARS = 4'h7;
   localparam logic [15:0] ZERO16         = 16'h0000;
   localparam int          BIT_SHIFT      = 4;      // 16 bits per word
endpackage : mb_slave_pkg

// ===== hw/mb_slave_port.sv
/*
 * Serial slave port core: frame end detection by silence, address filter,
 * class to database mapping, and response hold-off.
 * Assumes a receiver delivering rx_valid_i with rx_addr_i/rx_func_i/rx_point_i, a half-character
 * tick from the baud logic, and a database raising cmd_done_i when its work is done.
 */
// Overview of operation
// R1: wait configured milliseconds before sending response
// R2: accept only frames matching slave address
// R3: code 2 reads input bits from base
// R4: code 4 reads input words from base
// R5: coils read 1, written 5 and 15
// R6: holding read 3, written 6 and 16
// R7: input classes never written
// R8: frame end after 3.5 chars plus delay
// R9: zero extra delay uses plain silence
// R10: addresses map linearly from class base
`timescale 1ns/1ps
module mb_slave_port (
   // clock and reset
   input  wire logic                        core_clk_i,
   input  wire logic                        reset_n_i,
   // configuration
   input  wire logic [15:0]                 resp_delay_ms_i,
   input  wire logic [7:0]                  slave_id_i,
   input  wire logic [11:0]                 inbit_base_i,
   input  wire logic [11:0]                 inreg_base_i,
   input  wire logic [11:0]                 coil_base_i,
   input  wire logic [11:0]                 hold_base_i,
   input  wire logic [15:0]                 eom_delay_ms_i,
   // receive side
   input  wire logic                        rx_valid_i,
   input  wire logic                        half_char_tick_i,
   input  wire logic [7:0]                  rx_addr_i,
   input  wire logic [7:0]                  rx_func_i,
   input  wire logic [15:0]                 rx_point_i,
   // request to database
   input  wire logic                        cmd_done_i,
   output logic                             frame_end_o,
   output logic                             accept_o,
   output logic                             db_wr_o,
   output logic [mb_slave_pkg::DB_AW-1:0]   db_addr_o,
   output logic [3:0]                       db_bit_o,
   output logic                             tx_start_o
);
   import mb_slave_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_EXTRA, ST_HOLD} state_t;

   state_t       state_reg, state_next;
   logic [3:0]   sil_reg, sil_next;
   logic [16:0]  cyc_reg, cyc_next;
   logic [15:0]  ms_reg, ms_next;
   logic         end_reg, end_next;
   logic         acc_reg, acc_next;
   logic         wr_reg, wr_next;
   logic         ok_reg, ok_next;
   logic         wr_cls;
   logic [11:0]  addr_reg, addr_next;
   logic [3:0]   bit_reg, bit_next;
   logic         tx_reg, tx_next;
   logic         match;
   logic         bitcls;
   logic [11:0]  base;
   logic         known;
   logic         ms_tick;

   // ==========================================================================
   // request decode
   // only meaningful while the header strobe stands; the verdict is latched below
   always_comb begin
      match  = (slave_id_i <= SLAVE_ID_MAX) && (rx_addr_i == slave_id_i); // R2
      known  = 1'b1;
      bitcls = 1'b0;
      base   = 12'h000;
      wr_cls = 1'b0;
      unique case (rx_func_i)
         FC_RD_INBITS: begin // R3
            base   = inbit_base_i;
            bitcls = 1'b1;
         end
         FC_RD_INREG: begin // R4
            base = inreg_base_i;
         end
         FC_RD_COILS: begin // R5
            base   = coil_base_i;
            bitcls = 1'b1;
         end
         FC_WR_COIL, FC_WR_COILS: begin // R5
            base   = coil_base_i;
            bitcls = 1'b1;
            wr_cls = 1'b1;
         end
         FC_RD_HOLD: begin // R6
            base = hold_base_i;
         end
         FC_WR_HOLD, FC_WR_HOLDS: begin // R6
            base   = hold_base_i;
            wr_cls = 1'b1;
         end
         // input classes never reach this arm; unknown codes are dropped
         default: begin // R7
            known = 1'b0;
         end
      endcase
   end

   // ==========================================================================
   // frame timing and response hold-off
   assign ms_tick = (cyc_reg == MS_CNT_MAX);
   always_comb begin
      state_next = state_reg;
      sil_next   = sil_reg;
      cyc_next   = ms_tick ? 17'h00000 : cyc_reg + 17'h00001;
      ms_next    = ms_reg;
      end_next   = 1'b0;
      acc_next   = 1'b0;
      tx_next    = 1'b0;
      addr_next  = addr_reg;
      bit_next   = bit_reg;
      // write class and verdict are held from the request to the next one
      wr_next    = wr_reg;
      ok_next    = ok_reg;
      unique case (state_reg)
         ST_IDLE: if (rx_valid_i) begin
            state_next = ST_RX;
            sil_next   = 4'h0;
            acc_next   = 1'b0;
            // word classes step words, bit classes step bits
            if (bitcls) begin
               addr_next = base + 12'(rx_point_i >> BIT_SHIFT); // R10
               bit_next  = rx_point_i[3:0];                     // R10
            end else begin
               addr_next = base + rx_point_i[11:0];             // R10
               bit_next  = 4'h0;
            end
            // header lines go stale after the strobe, so the verdict is kept here
            ok_next = match && known; // R2
            // a base beyond the database end blocks the write altogether
            wr_next = wr_cls && match && known && (base <= BASE_MAX); // R7
         end
         ST_RX: begin
            if (rx_valid_i) sil_next = 4'h0;
            else if (half_char_tick_i) sil_next = sil_reg + 4'h1;
            if (sil_reg >= SIL_HALF_CHARS) begin // R8
               ms_next  = ZERO16;
               cyc_next = 17'h00000;
               if (eom_delay_ms_i == ZERO16) begin // R9
                  end_next   = 1'b1;
                  state_next = ST_HOLD;
               end else
                  state_next = ST_EXTRA;
            end
         end
         ST_EXTRA: begin
            if (rx_valid_i) begin
               state_next = ST_RX;
               sil_next   = 4'h0;
            end else if (ms_tick) begin
               ms_next = ms_reg + 16'h0001;
               if (ms_reg + 16'h0001 >= eom_delay_ms_i) begin // R8
                  end_next   = 1'b1;
                  ms_next    = ZERO16;
                  cyc_next   = 17'h00000;
                  state_next = ST_HOLD;
               end
            end
         end
         ST_HOLD: begin
            if (end_reg) acc_next = ok_reg; // R2
            if (ms_tick && ms_reg != resp_delay_ms_i) ms_next = ms_reg + 16'h0001;
            if (cmd_done_i && ms_reg >= resp_delay_ms_i) begin // R1
               tx_next    = ok_reg; // R2
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         sil_reg   <= 4'h0;
         cyc_reg   <= 17'h00000;
         ms_reg    <= 16'h0000;
         end_reg   <= 1'b0;
         acc_reg   <= 1'b0;
         wr_reg    <= 1'b0;
         ok_reg    <= 1'b0;
         addr_reg  <= 12'h000;
         bit_reg   <= 4'h0;
         tx_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         sil_reg   <= sil_next;
         cyc_reg   <= cyc_next;
         ms_reg    <= ms_next;
         end_reg   <= end_next;
         acc_reg   <= acc_next;
         wr_reg    <= wr_next;
         ok_reg    <= ok_next;
         addr_reg  <= addr_next;
         bit_reg   <= bit_next;
         tx_reg    <= tx_next;
      end
   end

   assign frame_end_o = end_reg;
   assign accept_o    = acc_reg;
   assign db_wr_o     = wr_reg && acc_reg; // R7
   assign db_addr_o   = addr_reg;
   assign db_bit_o    = bit_reg;
   assign tx_start_o  = tx_reg;

   // ==========================================================================
   // checks
   AST_TX_AFTER_DELAY: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R1
      tx_start_o |-> $past(ms_reg) >= $past(resp_delay_ms_i))
      else $error("response sent before hold-off");
   AST_ADDR_FILTER: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R2
      (state_reg == ST_IDLE && rx_valid_i && rx_addr_i != slave_id_i) |=> !ok_reg)
      else $error("foreign frame marked for acceptance");
   AST_ACCEPT_AFTER_END: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R2
      accept_o |-> ($past(frame_end_o) && ok_reg))
      else $error("accept without a finished matching frame");
   AST_NO_INPUT_WRITE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R7
      (state_reg == ST_IDLE && rx_valid_i && (rx_func_i == FC_RD_INBITS
       || rx_func_i == FC_RD_INREG)) |=> !wr_reg)
      else $error("write flagged for read-only class");
   AST_EOM_PLAIN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R9
      (state_reg == ST_RX && sil_reg >= SIL_HALF_CHARS && eom_delay_ms_i == ZERO16)
      |=> frame_end_o)
      else $error("plain silence did not end frame");
   AST_EOM_WAIT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R8
      frame_end_o |-> $past(state_reg) == ST_RX || $past(state_reg) == ST_EXTRA)
      else $error("frame end outside silence");
endmodule : mb_slave_port

// ===== test/mb_master_model.sv
/* remote master model: sends one request header per frame, then half-char ticks of silence.
   assumes the bench calls send() and drives the clock. */
`timescale 1ns/1ps
module mb_master_model (
   // clock
   input  wire logic        clk_i,
   // request side toward the port
   output logic             rx_valid_o,
   output logic             tick_o,
   output logic [7:0]       addr_o,
   output logic [7:0]       func_o,
   output logic [15:0]      point_o
);
   // ==========================================================================
   // idle lines at time zero
   initial begin
      rx_valid_o = 1'b0;
      tick_o     = 1'b0;
      {addr_o, func_o, point_o} = 32'h0;
   end
   // header is only valid with the strobe; after that it shows inverted garbage
   task automatic send(input logic [7:0] a, input logic [7:0] f, input logic [15:0] p);
      @(negedge clk_i);
      rx_valid_o <= 1'b1;
      {addr_o, func_o, point_o} <= {a, f, p};
      @(negedge clk_i);
      rx_valid_o <= 1'b0;
      {addr_o, func_o, point_o} <= ~{a, f, p};
      // eight ticks, one more than the silence needs
      repeat (8) begin
         repeat (3) @(negedge clk_i);
         tick_o <= 1'b1;
         @(negedge clk_i);
         tick_o <= 1'b0;
      end
   endtask : send
endmodule : mb_master_model

// ===== test/mb_slave_port_tb.sv
/* bench for the slave port: each function code, an unknown code and a foreign address.
   assumes zero delays, since one ms is a fixed 100000 cycles. */
`timescale 1ns/1ps
module mb_slave_port_tb;
   import mb_slave_pkg::*;
   logic        clk, rst_n, done, rxv, tick, fend, acc, wr, tx, hit;
   logic [7:0]  id, ra, rf, fc;
   logic [11:0] b_in, b_ir, b_co, b_ho, dba, e_a;
   logic [3:0]  dbb;
   logic [15:0] rp, pt;
   logic [7:0]  codes [10] = '{FC_RD_COILS, FC_RD_INBITS, FC_RD_HOLD, FC_RD_INREG, FC_WR_COIL,
                               FC_WR_HOLD, FC_WR_COILS, FC_WR_HOLDS, 8'h07, FC_WR_HOLD};
   int          num_errors, checks_done, i;
   bit          e_acc, e_wr, bitc;
   mb_master_model master_u (.clk_i(clk), .rx_valid_o(rxv), .tick_o(tick), .addr_o(ra),
                             .func_o(rf), .point_o(rp));
   mb_slave_port dut_u (.core_clk_i(clk), .reset_n_i(rst_n), .resp_delay_ms_i(16'h0000),
      .slave_id_i(id), .inbit_base_i(b_in), .inreg_base_i(b_ir), .coil_base_i(b_co),
      .hold_base_i(b_ho), .eom_delay_ms_i(16'h0000), .rx_valid_i(rxv),
      .half_char_tick_i(tick), .rx_addr_i(ra), .rx_func_i(rf), .rx_point_i(rp),
      .cmd_done_i(done), .frame_end_o(fend), .accept_o(acc), .db_wr_o(wr),
      .db_addr_o(dba), .db_bit_o(dbb), .tx_start_o(tx));
   // ==========================================================================
   // checking and closing
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================================
   // main sequence; the last two frames must be refused
   initial begin
      {rst_n, done, num_errors, checks_done} = '0;
      void'($urandom(32'h47d1f3a3));
      id = 8'($urandom_range(247));
      {b_in, b_ir, b_co, b_ho} = {12'($urandom_range(3998)), 12'($urandom_range(3998)),
                                  12'($urandom_range(3998)), 12'($urandom_range(3998))};
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      for (int k = 0; k < 10; k++) begin
         fc = codes[k];
         bitc = fc inside {FC_RD_COILS, FC_RD_INBITS, FC_WR_COIL, FC_WR_COILS};
         pt = bitc ? 16'($urandom_range(1023)) : 16'($urandom_range(63));
         e_acc = (k < 8);
         e_wr = e_acc && (fc inside {FC_WR_COIL, FC_WR_HOLD, FC_WR_COILS, FC_WR_HOLDS});
         case (fc)
            FC_RD_INBITS: e_a = b_in;
            FC_RD_INREG:  e_a = b_ir;
            FC_RD_HOLD, FC_WR_HOLD, FC_WR_HOLDS: e_a = b_ho;
            default:      e_a = b_co;
         endcase
         e_a = e_a + (bitc ? 12'(pt >> 4) : 12'(pt));
         fork
            master_u.send((k == 9) ? id ^ 8'h01 : id, fc, pt);
            begin
               for (i = 0; i < 100 && fend !== 1'b1; i++) @(negedge clk);
               chk("frame_end", fend, 1'b1);
               if (fend !== 1'b1) final_report();
               @(negedge clk);
               chk("accept", acc, e_acc);
               chk("db_wr", wr, e_wr);
               if (e_acc) chk("db_addr", dba, e_a);
               if (bitc && e_acc) chk("db_bit", dbb, pt[3:0]);
               else if (e_acc) chk("db_bit", dbb, 16'h0000);
            end
         join
         // response expected within 24 cycles; done is raised after the first 4, and a tx before it also counts
         hit = 1'b0;
         repeat (4) @(negedge clk) hit |= tx;
         done = 1'b1;
         for (i = 0; i < 20; i++) @(negedge clk) hit |= tx;
         chk("tx_start", hit, e_acc);
         done = 1'b0;
         $display("test code %h done", fc);
      end
      final_report();
   end
endmodule : mb_slave_port_tb
